// ==== hw/path_mon_pkg.sv ====
// Purpose: Shared constants and types for the path parity and remote error monitor
// Assumes: 8-bit register port, one STS-1 SPE byte stream on mclk_i
// Notes:   Offsets are byte addresses on the register port
package path_mon_pkg;

	localparam logic [11:0] ADDR_CONTROL_0    = 12'h183;
	localparam logic [11:0] ADDR_IRQ_STATUS_0 = 12'h18b;
	localparam logic [11:0] ADDR_IRQ_ENABLE_0 = 12'h18f;
	localparam logic [11:0] ADDR_B3_COUNT     = 12'ha98;
	localparam logic [11:0] ADDR_REI_COUNT    = 12'ha9c;

	localparam int          CTRL_PARITY_MODE  = 0;
	localparam int          CTRL_REMOTE_MODE  = 1;
	localparam int          CTRL_DEFECT_KIND  = 2;
	localparam int          CTRL_CHECK_STUFF  = 3;
	localparam int          STAT_B3_ERROR     = 7;
	localparam int          REI_NIBBLE_LSB    = 4;

	localparam logic [3:0]  CONTROL_RESET     = 4'h2;
	localparam logic [7:0]  IRQ_ENABLE_RESET  = 8'h80;
	localparam logic [3:0]  REI_MAX_VALUE     = 4'h8;

	typedef struct packed {
		logic       valid;
		logic       start;
		logic       b3;
		logic       g1;
		logic [7:0] data;
	} spe_byte_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	function automatic logic [3:0] ones_count(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

endpackage

// ==== hw/bip_check.sv ====
// Purpose: Even bit-interleaved parity over each SPE, checked against the next SPE's B3 byte
// Assumes: start marks the first byte of an SPE, b3 marks its B3 byte
// Notes:   The first SPE after reset has nothing to check against
`timescale 1ns/100ps
module bip_check
	import path_mon_pkg::*;
(
	input  wire logic      mclk_i,
	input  wire logic      rst_b_i,
	input  wire spe_byte_t spe_i,
	output logic           chk_o,
	output logic [7:0]     diff_o
);

	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic [7:0] prev_q;
	logic       prev_ok_q;
	logic       seen_q;
	logic       take_b3;

	assign acc_d   = spe_i.start ? spe_i.data : acc_q ^ spe_i.data;
	assign take_b3 = spe_i.valid && spe_i.b3 && prev_ok_q;

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			acc_q     <= 8'h00;
			prev_q    <= 8'h00;
			prev_ok_q <= 1'b0;
			seen_q    <= 1'b0;
			chk_o     <= 1'b0;
			diff_o    <= 8'h00;
		end
		else
		begin
			if (spe_i.valid)
				acc_q <= acc_d;
			if (spe_i.valid && spe_i.start)
			begin
				prev_q    <= acc_q;
				prev_ok_q <= seen_q;
				seen_q    <= 1'b1;
			end
			chk_o  <= take_b3;
			diff_o <= take_b3 ? (prev_q ^ spe_i.data) : 8'h00;
		end
	end

	chk_b3_compare : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		take_b3 |=> chk_o && diff_o == ($past(prev_q) ^ $past(spe_i.data)))
		else $error("B3 comparison result wrong");

	chk_parity_fold : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(spe_i.valid && !spe_i.start) |=> acc_q == ($past(acc_q) ^ $past(spe_i.data)))
		else $error("Parity accumulator did not fold byte");

endmodule // bip_check

// ==== hw/path_error_monitor.sv ====
// Purpose: Receive path B3 parity and remote error monitor for one STS-1 SPE channel
// Assumes: SPE bytes arrive flagged by upstream logic on mclk_i
// Notes:   Counters clear when their first byte address is read
`timescale 1ns/100ps
module path_error_monitor
	import path_mon_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire spe_byte_t   spe_i,
	input  wire reg_req_t    req_i,
	output logic [7:0]       rdata_o,
	output logic             int_b_o,
	output logic [3:0]       rei_tx_o,
	output logic             rei_tx_valid_o
);

	logic [3:0]  ctrl_q;
	logic [7:0]  status_q;
	logic [7:0]  irq_en_q;
	logic [31:0] b3_cnt_q;
	logic [31:0] rei_cnt_q;
	logic [31:0] b3_hold_q;
	logic [31:0] rei_hold_q;
	logic        chk;
	logic [7:0]  diff;

	logic        b3_err;
	logic [3:0]  bit_errs;
	logic [31:0] b3_add;
	logic [3:0]  rei_nib;
	logic        g1_take;
	logic [31:0] rei_add;
	logic        rd_status;
	logic        b3_clr;
	logic        rei_clr;
	logic [31:0] b3_base;
	logic [31:0] rei_base;
	logic [7:0]  status_d;
	logic [7:0]  rdata_d;
	logic [1:0]  byte_sel;
	logic        wr_ctrl;
	logic        wr_irq_en;
	logic [7:0]  status_set;

	bip_check u_bip (
		.mclk_i (mclk_i),
		.rst_b_i(rst_b_i),
		.spe_i  (spe_i),
		.chk_o  (chk),
		.diff_o (diff)
	);

	// Register port address decode
	function automatic logic rd_hit(input reg_req_t r, input logic [11:0] a);
		return r.rd && (r.addr == a);
	endfunction

	function automatic logic wr_hit(input reg_req_t r, input logic [11:0] a);
		return r.wr && (r.addr == a);
	endfunction

	assign bit_errs = ones_count(diff);
	assign b3_err   = chk && (diff != 8'h00);
	assign b3_add   = ctrl_q[CTRL_PARITY_MODE] ? {31'h0, b3_err} : {28'h0, bit_errs};

	assign rei_nib  = spe_i.data[REI_NIBBLE_LSB +: 4];
	assign g1_take  = spe_i.valid && spe_i.g1;
	assign rei_add  = !g1_take ? 32'h0 :
		ctrl_q[CTRL_REMOTE_MODE] ? {31'h0, rei_nib != 4'h0} :
		(rei_nib > REI_MAX_VALUE) ? 32'h0 : {28'h0, rei_nib};

	assign rd_status  = rd_hit(req_i, ADDR_IRQ_STATUS_0);
	assign b3_clr     = rd_hit(req_i, ADDR_B3_COUNT);
	assign rei_clr    = rd_hit(req_i, ADDR_REI_COUNT);
	assign wr_ctrl    = wr_hit(req_i, ADDR_CONTROL_0);
	assign wr_irq_en  = wr_hit(req_i, ADDR_IRQ_ENABLE_0);
	assign b3_base    = b3_clr ? 32'h0 : b3_cnt_q;
	assign rei_base   = rei_clr ? 32'h0 : rei_cnt_q;
	assign status_set = {7'h00, b3_err} << STAT_B3_ERROR;
	assign status_d   = (rd_status ? 8'h00 : status_q) | status_set;
	assign byte_sel  = req_i.addr[1:0];

	always_comb
	begin
		rdata_d = 8'h00;
		case (req_i.addr)
			ADDR_CONTROL_0:    rdata_d = {4'h0, ctrl_q};
			ADDR_IRQ_STATUS_0: rdata_d = status_q;
			ADDR_IRQ_ENABLE_0: rdata_d = irq_en_q;
			ADDR_B3_COUNT:     rdata_d = b3_cnt_q[31:24];
			ADDR_REI_COUNT:    rdata_d = rei_cnt_q[31:24];
			default:
			begin
				if (req_i.addr[11:2] == ADDR_B3_COUNT[11:2])
					rdata_d = b3_hold_q[8 * (3 - byte_sel) +: 8];
				else if (req_i.addr[11:2] == ADDR_REI_COUNT[11:2])
					rdata_d = rei_hold_q[8 * (3 - byte_sel) +: 8];
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_q         <= CONTROL_RESET;
			status_q       <= 8'h00;
			irq_en_q       <= IRQ_ENABLE_RESET;
			b3_cnt_q       <= 32'h0;
			rei_cnt_q      <= 32'h0;
			b3_hold_q      <= 32'h0;
			rei_hold_q     <= 32'h0;
			rdata_o        <= 8'h00;
			int_b_o        <= 1'b1;
			rei_tx_o       <= 4'h0;
			rei_tx_valid_o <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= req_i.wdata[3:0];
			if (wr_irq_en)
				irq_en_q <= req_i.wdata;
			if (b3_clr)
				b3_hold_q <= b3_cnt_q;
			if (rei_clr)
				rei_hold_q <= rei_cnt_q;
			status_q       <= status_d;
			b3_cnt_q       <= b3_base + b3_add;
			rei_cnt_q      <= rei_base + rei_add;
			rdata_o        <= req_i.rd ? rdata_d : 8'h00;
			int_b_o        <= ~|(status_d & irq_en_q);
			rei_tx_valid_o <= chk;
			if (chk)
				rei_tx_o <= ctrl_q[CTRL_PARITY_MODE] ? {3'h0, b3_err} : bit_errs;
		end
	end

	chk_rei_value_add : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(g1_take && !ctrl_q[CTRL_REMOTE_MODE] && !rei_clr && rei_nib <= REI_MAX_VALUE)
		|=> rei_cnt_q == $past(rei_cnt_q) + {28'h0, $past(rei_nib)})
		else $error("Remote counter did not add nibble value");

	chk_rei_spe_add : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(g1_take && ctrl_q[CTRL_REMOTE_MODE] && !rei_clr && rei_nib != 4'h0)
		|=> rei_cnt_q == $past(rei_cnt_q) + 32'h1)
		else $error("Remote counter did not add one per SPE");

	chk_b3_spe_add : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(b3_err && ctrl_q[CTRL_PARITY_MODE] && !b3_clr) |=> b3_cnt_q == $past(b3_cnt_q) + 32'h1)
		else $error("B3 counter did not add one per erred SPE");

	chk_b3_bit_add : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(chk && !ctrl_q[CTRL_PARITY_MODE] && !b3_clr)
		|=> b3_cnt_q == $past(b3_cnt_q) + {28'h0, ones_count($past(diff))})
		else $error("B3 counter did not add bit errors");

	chk_tx_spe_mode : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(chk && ctrl_q[CTRL_PARITY_MODE]) |=> rei_tx_valid_o && rei_tx_o == {3'h0, $past(b3_err)})
		else $error("Outgoing remote value wrong in per-SPE mode");

	chk_tx_bit_mode : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(chk && !ctrl_q[CTRL_PARITY_MODE]) |=> rei_tx_valid_o && rei_tx_o == ones_count($past(diff)))
		else $error("Outgoing remote value wrong in per-bit mode");

	chk_b3_irq_set : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		b3_err |=> status_q[STAT_B3_ERROR] && (int_b_o == !irq_en_q[STAT_B3_ERROR] || $past(req_i.wr)))
		else $error("B3 error did not raise status and interrupt");

	chk_count_snapshot : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		b3_clr |=> b3_hold_q == $past(b3_cnt_q) && rdata_o == $past(b3_cnt_q[31:24]))
		else $error("B3 count snapshot wrong");

	chk_irq_release : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(rd_status && !b3_err) |=> status_q == 8'h00 && int_b_o)
		else $error("Interrupt not released after status read");

	chk_rei_over_range : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(g1_take && !ctrl_q[CTRL_REMOTE_MODE] && !rei_clr && rei_nib > REI_MAX_VALUE)
		|=> rei_cnt_q == $past(rei_cnt_q))
		else $error("Remote counter took an out of range nibble");

	chk_rei_zero_skip : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(g1_take && ctrl_q[CTRL_REMOTE_MODE] && !rei_clr && rei_nib == 4'h0)
		|=> rei_cnt_q == $past(rei_cnt_q))
		else $error("Remote counter moved on a clean SPE");

	chk_rei_snapshot : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		rei_clr |=> rei_hold_q == $past(rei_cnt_q) && rdata_o == $past(rei_cnt_q[31:24]))
		else $error("Remote count snapshot wrong");

	chk_status_hold : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(!rd_status && !b3_err) |=> status_q == $past(status_q))
		else $error("Status changed without event or read");

	chk_tx_hold : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!chk |=> !rei_tx_valid_o && rei_tx_o == $past(rei_tx_o))
		else $error("Outgoing remote value moved without a check");

	chk_rdata_idle : assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!req_i.rd |=> rdata_o == 8'h00)
		else $error("Read data not idle without a read");

	cov_b3_error : cover property (@(posedge mclk_i) disable iff (!rst_b_i) b3_err);
	cov_rei_add  : cover property (@(posedge mclk_i) disable iff (!rst_b_i) g1_take && rei_nib != 4'h0);
	cov_clear    : cover property (@(posedge mclk_i) disable iff (!rst_b_i) b3_clr && b3_err);
	cov_spe_err  : cover property (@(posedge mclk_i) disable iff (!rst_b_i) b3_err && ctrl_q[CTRL_PARITY_MODE]);
	cov_rei_over : cover property (@(posedge mclk_i) disable iff (!rst_b_i) g1_take && rei_nib > REI_MAX_VALUE);

endmodule // path_error_monitor

// ==== sim/spe_source.sv ====
// Purpose: Far-end path terminal model sending SPEs with its own B3
// Assumes: Four-byte SPEs, driven just after the rising edge
// Notes:   Data line toggles once the SPE ends
`timescale 1ns/100ps
module spe_source
	import path_mon_pkg::*;
(
	input  wire logic mclk_i,
	output spe_byte_t spe_o
);
	logic [7:0] prev_q;
	logic [7:0] cur;
	initial
	begin
		prev_q = 8'h00;
		spe_o = '0;
	end
	task automatic put(input logic s, input logic b, input logic g, input logic [7:0] d);
		@(posedge mclk_i);
		spe_o <= '{1'b1, s, b, g, d};
		cur = cur ^ d;
	endtask
	// B3 carries the last SPE's parity with err bits flipped
	task automatic send(input logic [7:0] err, input logic [3:0] rei);
		cur = 8'h00;
		put(1'b1, 1'b0, 1'b0, 8'h3c);
		put(1'b0, 1'b1, 1'b0, prev_q ^ err);
		put(1'b0, 1'b0, 1'b1, {rei, 4'h0});
		put(1'b0, 1'b0, 1'b0, 8'ha5);
		prev_q = cur;
		@(posedge mclk_i);
		spe_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~spe_o.data};
	endtask
endmodule // spe_source

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the path error monitor
// Assumes: Register port pulses one cycle, read data one cycle later
// Notes:   Counts are read base byte first
`timescale 1ns/100ps
module tb
	import path_mon_pkg::*;
;
	logic        mclk_i;
	logic        rst_b_i;
	spe_byte_t   spe;
	reg_req_t    req;
	logic [7:0]  rdata;
	logic [7:0]  d;
	logic [31:0] c;
	logic        int_b;
	logic        rei_v;
	logic [3:0]  rei_tx;
	logic [3:0]  last_rei;
	int          fail_count = 0;
	int          n_checks = 0;
	int          n_rei = 0;

	spe_source spe_source_inst (.mclk_i(mclk_i), .spe_o(spe));
	path_error_monitor path_error_monitor_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .spe_i(spe), .req_i(req),
		.rdata_o(rdata), .int_b_o(int_b), .rei_tx_o(rei_tx), .rei_tx_valid_o(rei_v));

	initial
	begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i)
		if (rei_v === 1'b1)
		begin
			last_rei <= rei_tx;
			n_rei    <= n_rei + 1;
		end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge mclk_i);
		req <= '0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge mclk_i);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk_i);
		req <= '0;
		#1 d = rdata;
	endtask
	task automatic cnt(input logic [11:0] a);
		for (int i = 0; i < 4; i++)
		begin
			rd(a + 12'(i));
			c = {c[23:0], d};
		end
	endtask
	task automatic sendw(input logic [7:0] err, input logic [3:0] rei);
		spe_source_inst.send(err, rei);
		repeat (3) @(posedge mclk_i);
		#1;
	endtask

	task automatic t_reset;
		rd(ADDR_CONTROL_0);
		chk(d, 8'h02);
		rd(ADDR_IRQ_ENABLE_0);
		chk(d, 8'h80);
		chk(int_b, 1'b1);
		cnt(ADDR_B3_COUNT);
		chk(c, 0);
		sendw(8'h00, 4'h0);
		chk(n_rei, 0);
		$display("t_reset done");
	endtask
	task automatic t_bit;
		wr(ADDR_CONTROL_0, 8'h00);
		sendw(8'h00, 4'h5);
		chk(last_rei, 4'h0);
		sendw(8'h0b, 4'h9);
		chk(last_rei, 4'h3);
		sendw(8'hff, 4'h8);
		chk(last_rei, 4'h8);
		chk(n_rei, 3);
		chk(int_b, 1'b0);
		cnt(ADDR_B3_COUNT);
		chk(c, 32'h0000000b);
		cnt(ADDR_REI_COUNT);
		chk(c, 32'h0000000d);
		cnt(ADDR_B3_COUNT);
		chk(c, 0);
		rd(ADDR_IRQ_STATUS_0);
		chk(d, 8'h80);
		chk(int_b, 1'b1);
		rd(ADDR_IRQ_STATUS_0);
		chk(d, 8'h00);
		$display("t_bit done");
	endtask
	task automatic t_spe;
		wr(ADDR_CONTROL_0, 8'hff);
		rd(ADDR_CONTROL_0);
		chk(d, 8'h0f);
		sendw(8'h81, 4'h7);
		chk(last_rei, 4'h1);
		sendw(8'h00, 4'h0);
		chk(last_rei, 4'h0);
		cnt(ADDR_B3_COUNT);
		chk(c, 32'h1);
		cnt(ADDR_REI_COUNT);
		chk(c, 32'h1);
		rd(ADDR_IRQ_STATUS_0);
		chk(d, 8'h80);
		chk(n_rei, 5);
		$display("t_spe done");
	endtask
	task automatic t_mask;
		wr(ADDR_IRQ_ENABLE_0, 8'h00);
		sendw(8'h01, 4'h0);
		chk(int_b, 1'b1);
		rd(ADDR_IRQ_STATUS_0);
		chk(d, 8'h80);
		wr(ADDR_IRQ_ENABLE_0, 8'h80);
		wr(12'h000, 8'h55);
		rd(12'h000);
		chk(d, 8'h00);
		chk(int_b, 1'b1);
		$display("t_mask done");
	endtask

	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		fail_count++;
		end_of_test;
	end
	initial
	begin
		rst_b_i = 1'b0;
		req = '0;
		last_rei = '0;
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		t_reset;
		t_bit;
		t_spe;
		t_mask;
		end_of_test;
	end
endmodule // tb
